// ===== rtl/ifba_pkg.sv
// Constants shared by both ends of the indirect feature bit access link.
// Assumes byte-wide register access on the management side.
`default_nettype none
package ifba_pkg;
	// ----------------------------------------------------------------
	// Device register map
	// ----------------------------------------------------------------
	localparam logic [7:0] IFBA_OFF_UNLOCK  = 8'h08;
	localparam logic [7:0] IFBA_OFF_SELECT  = 8'h09;
	localparam logic [7:0] IFBA_OFF_COMMAND = 8'h0a;
	localparam logic [7:0] IFBA_ACCESS_CODE = 8'hbb;
	localparam logic [7:0] IFBA_CLOSE_CODE  = 8'h00;
	localparam logic [7:0] IFBA_SELECT_RST  = 8'h00;
	// ----------------------------------------------------------------
	// Command byte fields
	// ----------------------------------------------------------------
	localparam int IFBA_CMD_WE_BIT   = 7;
	localparam int IFBA_CMD_RD_BIT   = 6;
	localparam int IFBA_CMD_WVAL_BIT = 1;
	// ----------------------------------------------------------------
	// Feature bit bank
	// ----------------------------------------------------------------
	localparam int IFBA_NUM_FEAT          = 256;
	localparam int IFBA_FEAT_DELAY_LSB    = 132;
	localparam int IFBA_FEAT_TRIM0_LSB    = 140;
	localparam int IFBA_FEAT_TRIM0_MSB    = 143;
	localparam logic [IFBA_NUM_FEAT-1:0] IFBA_FEAT_RST =
		{{(IFBA_NUM_FEAT-1){1'b0}}, 1'b1} << IFBA_FEAT_TRIM0_MSB;
	// ----------------------------------------------------------------
	// Host controller register map
	// ----------------------------------------------------------------
	localparam logic [7:0] IFBA_H_OFF_CTRL   = 8'h00;
	localparam logic [7:0] IFBA_H_OFF_ADDR   = 8'h01;
	localparam logic [7:0] IFBA_H_OFF_STATUS = 8'h02;
	localparam int IFBA_H_CTRL_GO    = 0;
	localparam int IFBA_H_CTRL_WRITE = 1;
	localparam int IFBA_H_CTRL_VALUE = 2;
	localparam int IFBA_H_ST_BUSY    = 0;
	localparam int IFBA_H_ST_DONE    = 1;
	localparam int IFBA_H_ST_RESULT  = 2;
	localparam logic [7:0] IFBA_H_ADDR_RST = 8'h00;

	typedef enum logic [2:0] {
		IFBA_H_IDLE,
		IFBA_H_UNLOCK,
		IFBA_H_SELECT,
		IFBA_H_READ,
		IFBA_H_CAPTURE,
		IFBA_H_WCMD,
		IFBA_H_CLOSE
	} ifba_hstate_t;
endpackage
`default_nettype wire

// ===== rtl/ifba_mgmt_if.sv
// Management register link between the host controller and the device.
// Assumes one clock shared by both ends; read data follow a read by one cycle.
`timescale 1ns/1ps
`default_nettype none
interface ifba_mgmt_if;
	logic [7:0] mgmt_addr;
	logic [7:0] mgmt_wdata;
	logic       mgmt_wr;
	logic       mgmt_rd;
	logic [7:0] mgmt_rdata;

	modport host (
		output mgmt_addr,
		output mgmt_wdata,
		output mgmt_wr,
		output mgmt_rd,
		input  mgmt_rdata
	);

	modport device (
		input  mgmt_addr,
		input  mgmt_wdata,
		input  mgmt_wr,
		input  mgmt_rd,
		output mgmt_rdata
	);
endinterface
`default_nettype wire

// ===== rtl/ifba_feature_cell.sv
// One stored feature bit with its own power-up value.
// Assumes the write enable is a single-cycle strobe from the device logic.
`timescale 1ns/1ps
`default_nettype none
module ifba_feature_cell #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic clk_sys_in,
	input  wire logic rst_b_in,
	// Update
	input  wire logic wr_en_in,
	input  wire logic wr_val_in,
	// State
	output var  logic bit_out
);
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bit_out <= RST_VAL;
		end else if (wr_en_in) begin
			bit_out <= wr_val_in;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/ifba_device.sv
// Device end: unlock, select and command bytes over a bank of feature bits.
// Assumes the management master obeys the strobe timing of ifba_mgmt_if.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Select and command reachable only after 0xBB
// - Locked: ignore writes, return zero reads
// - Unlock byte is write-only, never read back
// - Full select byte picks unique feature bit
// - Command read shows selected bit at 6
// - Command write with bit 7 stores bit 1
// - Host closes write before changing address
// - Host reads: unlock, select, read command
// - Host writes: unlock, select, pattern, close
// - Select byte is plain binary bit number
// - Output 0 trim MSB at 143, resets 1
// - Input delay at 132 to 135, resets 0
module ifba_device (
	// Clock and reset
	input  wire logic                              clk_sys_in,
	input  wire logic                              rst_b_in,
	// Management link
	ifba_mgmt_if.device                            mgmt,
	// Feature bit state
	output var  logic [ifba_pkg::IFBA_NUM_FEAT-1:0] feature_bits_out,
	output var  logic [3:0]                        output0_drive_trim_out,
	output var  logic [3:0]                        input_delay_out,
	// Status
	output var  logic                              unlocked_out,
	output var  logic                              write_open_out
);
	import ifba_pkg::*;

	// ----------------------------------------------------------------
	// Link register map
	// ----------------------------------------------------------------
	// 08: unlock byte, write only; the access code opens 09 and 0a.
	// 09: select byte, the number of the feature bit that 0a reaches.
	// 0a: command byte; bit 7 enables a write of bit 1, bit 6 reads.
	// Other offsets, and 09 and 0a while locked, read as zero.
	// A relock keeps the select byte and the bank; only a power-up
	// reset returns them to their defaults.
	// Write-open is status only: it never blocks a store or a move.

	logic       unlocked_reg;
	logic [7:0] select_reg;
	logic       write_open_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic       hit_unlock;
	logic       hit_select;
	logic       hit_command;
	logic       bit_wr_en;
	logic       sel_bit;
	logic [IFBA_NUM_FEAT-1:0] feat_bits;
	logic       wr_unlock;
	logic       wr_select;
	logic       wr_command;
	logic       rd_select;
	logic       rd_command;
	logic       write_val;
	logic [IFBA_NUM_FEAT-1:0] cell_wr_en;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	assign hit_unlock  = (mgmt.mgmt_addr == IFBA_OFF_UNLOCK);
	assign hit_select  = (mgmt.mgmt_addr == IFBA_OFF_SELECT);
	assign hit_command = (mgmt.mgmt_addr == IFBA_OFF_COMMAND);

	// ----------------------------------------------------------------
	// Access qualification
	// ----------------------------------------------------------------
	// Select and command accesses only count while unlocked; a locked
	// access falls through exactly as an unmapped one would. The
	// unlock byte itself is writable in either state.
	assign wr_unlock  = mgmt.mgmt_wr && hit_unlock;
	assign wr_select  = mgmt.mgmt_wr && hit_select && unlocked_reg;
	assign wr_command = mgmt.mgmt_wr && hit_command && unlocked_reg;
	assign rd_select  = mgmt.mgmt_rd && hit_select && unlocked_reg;
	assign rd_command = mgmt.mgmt_rd && hit_command && unlocked_reg;
	assign write_val  = mgmt.mgmt_wdata[IFBA_CMD_WVAL_BIT];

	// ----------------------------------------------------------------
	// Unlock state
	// ----------------------------------------------------------------
	// Only the comparison result is kept; the written byte itself is
	// never stored, so there is nothing to read back. Any other byte
	// at this offset locks again, so a stray write in the middle of a
	// sequence shuts the indirect bytes rather than leaving them open.
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			unlocked_reg <= 1'b0;
		end else if (wr_unlock) begin
			unlocked_reg <= (mgmt.mgmt_wdata == IFBA_ACCESS_CODE);
		end
	end

	// ----------------------------------------------------------------
	// Feature bit select
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			select_reg <= IFBA_SELECT_RST;
		end else if (wr_select) begin
			select_reg <= mgmt.mgmt_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Command write
	// ----------------------------------------------------------------
	// Bit 7 of a command byte enables the store; the reserved bits of
	// a written command byte are ignored.
	assign bit_wr_en = wr_command &&
		mgmt.mgmt_wdata[IFBA_CMD_WE_BIT];

	// Tracks a write that the host has not yet closed with a command byte whose bit 7 is clear.
	// A new write-enabled command while open keeps it open. The store
	// itself happens at once; a host that skips the closing byte leaves
	// the bank correct but this window open.
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			write_open_reg <= 1'b0;
		end else if (bit_wr_en) begin
			write_open_reg <= 1'b1;
		end else if (wr_command) begin
			write_open_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Feature bit bank
	// ----------------------------------------------------------------
	// Each cell compares the whole select byte, so no two feature bits
	// share an address and a write reaches exactly one cell. The cell
	// number is cut to the eight bits of the select byte on purpose.
	genvar gd;
	generate
		for (gd = 0; gd < IFBA_NUM_FEAT; gd++) begin : g_dec
			assign cell_wr_en[gd] = bit_wr_en &&
				(select_reg == 8'(gd));
		end
	endgenerate

	// Every bit is a cell of its own with a fixed power-up value; only
	// the trim MSB of output 0 starts at one.
	genvar gi;
	generate
		for (gi = 0; gi < IFBA_NUM_FEAT; gi++) begin : g_cell
			ifba_feature_cell #(
				.RST_VAL (IFBA_FEAT_RST[gi])
			) u_cell (
				.clk_sys_in (clk_sys_in),
				.rst_b_in   (rst_b_in),
				.wr_en_in   (cell_wr_en[gi]),
				.wr_val_in  (write_val),
				.bit_out    (feat_bits[gi])
			);
		end
	endgenerate

	assign sel_bit = feat_bits[select_reg];

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// The unlock offset has no read branch, so the access code never
	// leaves the device; a command read carries nothing but the bit
	// of the selected cell.
	always_comb begin
		rdata_next = 8'h00;
		if (rd_select) begin
			rdata_next = select_reg;
		end else if (rd_command) begin
			rdata_next[IFBA_CMD_RD_BIT] = sel_bit;
		end
	end

	// Read data stand only in the cycle after the read strobe; an
	// unlock read, a locked read or an unmapped address gives zero.
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign mgmt.mgmt_rdata = rdata_reg;

	// ----------------------------------------------------------------
	// User-side outputs
	// ----------------------------------------------------------------
	// The named fields are plain slices of the bank; they follow a
	// cell write in the next cycle and hold no state of their own, so
	// a user sees a new value one cycle before a command read could return it.
	assign feature_bits_out       = feat_bits;
	assign output0_drive_trim_out =
		feat_bits[IFBA_FEAT_TRIM0_MSB:IFBA_FEAT_TRIM0_LSB];
	assign input_delay_out        =
		feat_bits[IFBA_FEAT_DELAY_LSB+3:IFBA_FEAT_DELAY_LSB];
	assign unlocked_out           = unlocked_reg;
	assign write_open_out         = write_open_reg;
endmodule
`default_nettype wire

// ===== rtl/ifba_host.sv
// Host end: runs feature bit read and write sequences on the link.
// Assumes software drives the user port with one-cycle strobes.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ifba_host (
	// Clock and reset
	input  wire logic       clk_sys_in,
	input  wire logic       rst_b_in,
	// Software register port
	input  wire logic [7:0] user_addr_in,
	input  wire logic [7:0] user_wdata_in,
	input  wire logic       user_wr_in,
	input  wire logic       user_rd_in,
	output var  logic [7:0] user_rdata_out,
	// Management link
	ifba_mgmt_if.host       mgmt
);
	import ifba_pkg::*;

	ifba_hstate_t state_reg;
	ifba_hstate_t state_next;
	logic [7:0]   feat_addr_reg;
	logic         op_write_reg;
	logic         op_value_reg;
	logic         done_reg;
	logic         result_reg;
	logic [7:0]   user_rdata_reg;
	logic [7:0]   l_addr_reg;
	logic [7:0]   l_wdata_reg;
	logic         l_wr_reg;
	logic         l_rd_reg;
	logic         busy;
	logic         go;

	assign busy = (state_reg != IFBA_H_IDLE);
	assign go   = user_wr_in && (user_addr_in == IFBA_H_OFF_CTRL) &&
		user_wdata_in[IFBA_H_CTRL_GO] && !busy;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			IFBA_H_IDLE:    if (go) state_next = IFBA_H_UNLOCK;
			IFBA_H_UNLOCK:  state_next = IFBA_H_SELECT;
			IFBA_H_SELECT:  state_next = op_write_reg ? IFBA_H_WCMD :
				IFBA_H_READ;
			IFBA_H_READ:    state_next = IFBA_H_CAPTURE;
			IFBA_H_CAPTURE: state_next = IFBA_H_IDLE;
			IFBA_H_WCMD:    state_next = IFBA_H_CLOSE;
			IFBA_H_CLOSE:   state_next = IFBA_H_IDLE;
			default:        state_next = IFBA_H_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= IFBA_H_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Link drive, registered from the state being entered
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			l_addr_reg  <= 8'h00;
			l_wdata_reg <= 8'h00;
			l_wr_reg    <= 1'b0;
			l_rd_reg    <= 1'b0;
		end else begin
			l_addr_reg  <= 8'h00;
			l_wdata_reg <= 8'h00;
			l_wr_reg    <= 1'b0;
			l_rd_reg    <= 1'b0;
			unique case (state_next)
				IFBA_H_UNLOCK: begin
					l_addr_reg  <= IFBA_OFF_UNLOCK;
					l_wdata_reg <= IFBA_ACCESS_CODE;
					l_wr_reg    <= 1'b1;
				end
				IFBA_H_SELECT: begin
					l_addr_reg  <= IFBA_OFF_SELECT;
					l_wdata_reg <= feat_addr_reg;
					l_wr_reg    <= 1'b1;
				end
				IFBA_H_READ: begin
					l_addr_reg <= IFBA_OFF_COMMAND;
					l_rd_reg   <= 1'b1;
				end
				IFBA_H_WCMD: begin
					l_addr_reg <= IFBA_OFF_COMMAND;
					l_wdata_reg[IFBA_CMD_WE_BIT]   <= 1'b1;
					l_wdata_reg[IFBA_CMD_WVAL_BIT] <= op_value_reg;
					l_wr_reg   <= 1'b1;
				end
				IFBA_H_CLOSE: begin
					l_addr_reg  <= IFBA_OFF_COMMAND;
					l_wdata_reg <= IFBA_CLOSE_CODE;
					l_wr_reg    <= 1'b1;
				end
				IFBA_H_IDLE, IFBA_H_CAPTURE: begin
				end
			endcase
		end
	end

	assign mgmt.mgmt_addr  = l_addr_reg;
	assign mgmt.mgmt_wdata = l_wdata_reg;
	assign mgmt.mgmt_wr    = l_wr_reg;
	assign mgmt.mgmt_rd    = l_rd_reg;

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			feat_addr_reg <= IFBA_H_ADDR_RST;
		end else if (user_wr_in && user_addr_in == IFBA_H_OFF_ADDR && !busy) begin
			feat_addr_reg <= user_wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			op_write_reg <= 1'b0;
			op_value_reg <= 1'b0;
		end else if (go) begin
			op_write_reg <= user_wdata_in[IFBA_H_CTRL_WRITE];
			op_value_reg <= user_wdata_in[IFBA_H_CTRL_VALUE];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			result_reg <= 1'b0;
		end else if (state_reg == IFBA_H_CAPTURE) begin
			result_reg <= mgmt.mgmt_rdata[IFBA_CMD_RD_BIT];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			done_reg <= 1'b0;
		end else if (busy && state_next == IFBA_H_IDLE) begin
			done_reg <= 1'b1;
		end else if (go) begin
			done_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			user_rdata_reg <= 8'h00;
		end else begin
			user_rdata_reg <= 8'h00;
			if (user_rd_in) begin
				unique case (user_addr_in)
					IFBA_H_OFF_ADDR: user_rdata_reg <= feat_addr_reg;
					IFBA_H_OFF_STATUS: begin
						user_rdata_reg[IFBA_H_ST_BUSY]   <= busy;
						user_rdata_reg[IFBA_H_ST_DONE]   <= done_reg;
						user_rdata_reg[IFBA_H_ST_RESULT] <= result_reg;
					end
					default: user_rdata_reg <= 8'h00;
				endcase
			end
		end
	end

	assign user_rdata_out = user_rdata_reg;
endmodule
`default_nettype wire

// ===== verification/ifba_link_sva.sv
// Checker for the management link between the host and device ends.
// Assumes the bench hands in the link signals of the joined pair.
`timescale 1ns/1ps
`default_nettype none
module ifba_link_sva
	import ifba_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys_in,
	input wire logic       rst_b_in,
	// Link signals
	input wire logic [7:0] mgmt_addr,
	input wire logic [7:0] mgmt_wdata,
	input wire logic       mgmt_wr,
	input wire logic       mgmt_rd,
	input wire logic [7:0] mgmt_rdata
);
	logic                     unl_reg;
	logic [7:0]               sel_reg;
	logic [IFBA_NUM_FEAT-1:0] shadow_reg;
	logic                     cur_bit;

	assign cur_bit = shadow_reg[sel_reg];

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			unl_reg <= 1'b0;
		end else if (mgmt_wr && mgmt_addr == IFBA_OFF_UNLOCK) begin
			unl_reg <= (mgmt_wdata == IFBA_ACCESS_CODE);
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sel_reg <= IFBA_SELECT_RST;
		end else if (mgmt_wr && unl_reg && mgmt_addr == IFBA_OFF_SELECT) begin
			sel_reg <= mgmt_wdata;
		end
	end

	// Shadow of the feature bank, so read values can be predicted.
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			shadow_reg <= IFBA_FEAT_RST;
		end else if (mgmt_wr && unl_reg && mgmt_addr == IFBA_OFF_COMMAND &&
				mgmt_wdata[7]) begin
			shadow_reg[sel_reg] <= mgmt_wdata[1];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_b_in);

	chk_strobe_excl: assert property (!(mgmt_wr && mgmt_rd))
		else $error("write and read strobes together");
	chk_rdata_idle: assert property (!$past(mgmt_rd) |-> mgmt_rdata == 8'h00)
		else $error("read data outside the answer cycle");
	chk_cmd_zero: assert property (
		mgmt_rd && mgmt_addr == IFBA_OFF_COMMAND |=>
		mgmt_rdata[7] == 1'b0 && mgmt_rdata[5:0] == 6'h00)
		else $error("command read shows stray bits");
	chk_cmd_value: assert property (
		mgmt_rd && mgmt_addr == IFBA_OFF_COMMAND && unl_reg |=>
		mgmt_rdata[6] == $past(cur_bit))
		else $error("command read shows wrong feature bit");
	chk_unlock_code: assert property (
		mgmt_wr && mgmt_addr == IFBA_OFF_UNLOCK |->
		mgmt_wdata == IFBA_ACCESS_CODE)
		else $error("unlock write without access code");
	chk_seq_select: assert property (
		mgmt_wr && mgmt_addr == IFBA_OFF_UNLOCK |=>
		mgmt_wr && mgmt_addr == IFBA_OFF_SELECT)
		else $error("select does not follow unlock");
	chk_seq_cmd: assert property (
		mgmt_wr && mgmt_addr == IFBA_OFF_SELECT |=>
		(mgmt_wr || mgmt_rd) && mgmt_addr == IFBA_OFF_COMMAND)
		else $error("command access does not follow select");
	chk_write_close: assert property (
		mgmt_wr && mgmt_addr == IFBA_OFF_COMMAND && mgmt_wdata[7] |=>
		mgmt_wr && mgmt_addr == IFBA_OFF_COMMAND &&
		mgmt_wdata == IFBA_CLOSE_CODE)
		else $error("feature write not closed");
	chk_write_pattern: assert property (
		mgmt_wr && mgmt_addr == IFBA_OFF_COMMAND |->
		mgmt_wdata[6:2] == 5'h00 && mgmt_wdata[0] == 1'b0)
		else $error("command write pattern malformed");

	cov_read: cover property (mgmt_rd && mgmt_addr == IFBA_OFF_COMMAND);
	cov_write: cover property (mgmt_wr && mgmt_addr == IFBA_OFF_COMMAND &&
		mgmt_wdata[7]);
	cov_read_one: cover property (mgmt_rd ##1 mgmt_rdata[6]);
endmodule
`default_nettype wire

// ===== verification/tb_indirect_feature_bit_access.sv
// Testbench: host and device ends joined, plus a lone device driven here.
// Assumes a 40 MHz clock and the ifba_pkg constants.
`timescale 1ns/1ps
`default_nettype none
module tb_indirect_feature_bit_access;
	import ifba_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] user_addr = 8'h00;
	logic [7:0] user_wdata = 8'h00;
	logic user_wr = 1'b0;
	logic user_rd = 1'b0;
	logic [7:0] user_rdata;
	logic [IFBA_NUM_FEAT-1:0] bits_a, bits_b;
	logic [3:0] trim_a, trim_b, dly_a, dly_b;
	logic unl_a, unl_b, wop_a, wop_b;
	int mismatches = 0;
	int checked = 0;
	logic [7:0] st, q;
	// Rows: feature address, write, value, expected read result.
	logic [10:0] rows [9] = '{
		{8'd143, 3'b001}, {8'd132, 3'b000}, {8'd132, 3'b110},
		{8'd132, 3'b001}, {8'd143, 3'b100}, {8'd143, 3'b000},
		{8'd255, 3'b110}, {8'd255, 3'b001}, {8'd0, 3'b000}};

	always #12.5 clk_sys_in = ~clk_sys_in;

	ifba_mgmt_if link ();
	ifba_mgmt_if lone ();
	initial begin
		lone.mgmt_addr = 8'h00;
		lone.mgmt_wdata = 8'h00;
		lone.mgmt_wr = 1'b0;
		lone.mgmt_rd = 1'b0;
	end

	ifba_host ifba_host_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.user_addr_in(user_addr), .user_wdata_in(user_wdata),
		.user_wr_in(user_wr), .user_rd_in(user_rd),
		.user_rdata_out(user_rdata), .mgmt(link.host));
	ifba_device ifba_device_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.mgmt(link.device), .feature_bits_out(bits_a),
		.output0_drive_trim_out(trim_a), .input_delay_out(dly_a),
		.unlocked_out(unl_a), .write_open_out(wop_a));
	ifba_device ifba_device_b_i (.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in), .mgmt(lone.device), .feature_bits_out(bits_b),
		.output0_drive_trim_out(trim_b), .input_delay_out(dly_b),
		.unlocked_out(unl_b), .write_open_out(wop_b));
	ifba_link_sva ifba_link_sva_i (.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in), .mgmt_addr(link.mgmt_addr),
		.mgmt_wdata(link.mgmt_wdata), .mgmt_wr(link.mgmt_wr),
		.mgmt_rd(link.mgmt_rd), .mgmt_rdata(link.mgmt_rdata));

	task automatic chk(input string nm, input logic [7:0] seen,
			input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
			mismatches++;
		end
	endtask

	task automatic uwr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		user_addr <= a;
		user_wdata <= d;
		user_wr <= 1'b1;
		@(posedge clk_sys_in);
		user_wr <= 1'b0;
	endtask

	task automatic urd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		user_addr <= a;
		user_rd <= 1'b1;
		@(posedge clk_sys_in);
		user_rd <= 1'b0;
		@(negedge clk_sys_in);
		d = user_rdata;
	endtask

	task automatic dwr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		lone.mgmt_addr <= a;
		lone.mgmt_wdata <= d;
		lone.mgmt_wr <= 1'b1;
		@(posedge clk_sys_in);
		lone.mgmt_wr <= 1'b0;
		@(negedge clk_sys_in);
	endtask

	task automatic drd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		lone.mgmt_addr <= a;
		lone.mgmt_rd <= 1'b1;
		@(posedge clk_sys_in);
		lone.mgmt_rd <= 1'b0;
		@(negedge clk_sys_in);
		d = lone.mgmt_rdata;
	endtask

	task automatic hop(input logic [7:0] a, input logic w, input logic v);
		uwr(IFBA_H_OFF_ADDR, a);
		uwr(IFBA_H_OFF_CTRL, {5'h00, v, w, 1'b1});
		st = 8'h00;
		for (int i = 0; i < 20 && st[IFBA_H_ST_DONE] !== 1'b1; i++)
			urd(IFBA_H_OFF_STATUS, st);
	endtask

	task automatic test_done();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#(25 * 5000);
		mismatches++;
		test_done();
	end

	initial begin
		repeat (12) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		foreach (rows[k]) begin
			hop(rows[k][10:3], rows[k][2], rows[k][1]);
			chk("done", st[IFBA_H_ST_DONE], 1'b1);
			if (!rows[k][2])
				chk("result", st[IFBA_H_ST_RESULT], rows[k][0]);
		end
		chk("delay", dly_a, 4'h1);
		chk("trim", trim_a, 4'h0);
		chk("bit255", bits_a[255], 1'b1);
		chk("unl a", unl_a, 1'b1);
		chk("wop a", wop_a, 1'b0);
		$display("test host rows done");
		chk("rst trim", trim_b, 4'h8);
		chk("rst delay", dly_b, 4'h0);
		dwr(IFBA_OFF_SELECT, 8'h8f);
		dwr(IFBA_OFF_COMMAND, 8'h80);
		drd(IFBA_OFF_COMMAND, q);
		chk("locked cmd", q, 8'h00);
		chk("locked bit", bits_b[143], 1'b1);
		dwr(IFBA_OFF_UNLOCK, IFBA_ACCESS_CODE);
		chk("unlocked", unl_b, 1'b1);
		drd(IFBA_OFF_UNLOCK, q);
		chk("unlock rd", q, 8'h00);
		dwr(IFBA_OFF_SELECT, 8'h8f);
		drd(IFBA_OFF_SELECT, q);
		chk("select rd", q, 8'h8f);
		drd(IFBA_OFF_COMMAND, q);
		chk("cmd 143", q, 8'h40);
		dwr(IFBA_OFF_COMMAND, 8'h80);
		chk("open", wop_b, 1'b1);
		chk("trim wr", trim_b, 4'h0);
		dwr(IFBA_OFF_COMMAND, IFBA_CLOSE_CODE);
		chk("closed", wop_b, 1'b0);
		dwr(IFBA_OFF_SELECT, 8'b1000_0100);
		dwr(IFBA_OFF_COMMAND, 8'h82);
		dwr(IFBA_OFF_COMMAND, IFBA_CLOSE_CODE);
		chk("delay wr", dly_b, 4'h1);
		dwr(8'h0b, 8'hff);
		drd(8'h0b, q);
		chk("unmapped", q, 8'h00);
		dwr(IFBA_OFF_UNLOCK, 8'hbc);
		chk("relocked", unl_b, 1'b0);
		drd(IFBA_OFF_SELECT, q);
		chk("locked sel", q, 8'h00);
		dwr(IFBA_OFF_SELECT, 8'h00);
		dwr(IFBA_OFF_UNLOCK, IFBA_ACCESS_CODE);
		drd(IFBA_OFF_SELECT, q);
		chk("sel kept", q, 8'h84);
		$display("test lone device done");
		@(posedge clk_sys_in);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		@(negedge clk_sys_in);
		chk("rst unl", unl_b, 1'b0);
		chk("rst trim2", trim_b, 4'h8);
		chk("rst dly2", dly_b, 4'h0);
		hop(8'd143, 1'b0, 1'b0);
		chk("rst rd143", st[IFBA_H_ST_RESULT], 1'b1);
		uwr(IFBA_H_OFF_CTRL, 8'h01);
		uwr(IFBA_H_OFF_ADDR, 8'h00);
		urd(IFBA_H_OFF_STATUS, st);
		chk("busy", st[IFBA_H_ST_BUSY], 1'b1);
		repeat (4) @(posedge clk_sys_in);
		urd(IFBA_H_OFF_STATUS, st);
		chk("done2", st[IFBA_H_ST_DONE], 1'b1);
		chk("rd143 again", st[IFBA_H_ST_RESULT], 1'b1);
		urd(IFBA_H_OFF_ADDR, q);
		chk("host addr", q, 8'h8f);
		$display("test second reset done");
		test_done();
	end
endmodule
`default_nettype wire
